// >>> hdl/startup_pkg.sv
// Constants shared by the transceiver start-up sequencer and its link partner.
// Assumes a single 200 MHz clock; slower rates are enable pulses.
// What this block does
// R1 - Hold DIR until PLL lock
// R2 - Reference clock rising edges only
// R3 - ULPI clock derived from reference via PLL
// R4 - Late reference clock delays start equally
// R5 - Reset pin low blocks start-up
// R6 - Link stops reference after last write
// R7 - STP wakes device from low power
// R8 - Link restarts reference with STP
// R9 - Lost reference drops PLL lock, minimum frequency
// R10 - Two-bit regulator level in UART mode
// R11 - Run only when POR and pin high
// R12 - Reset pin low 1 us resets state, DIR and level
// R13 - Registers default on core supply power-up
// R14 - Link always drives reset pin
// R15 - Link holds reset until supply stable
// R16 - No USB supply: register access only
// R17 - Synchronous mode after power-on
// R18 - Idle data and DIR high until lock
// R19 - DIR stays high while STP high
// R20 - Link drives idle after DIR falls
// R21 - Reset release needs no clock alignment
// R22 - Host link sets auto-resume enable
// R23 - Synchronise reset release before sequencing
package startup_pkg;
	localparam int CLK_MHZ = 200;
	localparam int RESET_MIN_NS = 1000;
	// Least time rounds up
	localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
	localparam int LOCK_EDGES = 64; // Reference edges counted before lock is declared
	localparam int REF_LOSS_CYC = 64; // Clock cycles without a reference edge = lost
	localparam int MIN_DIV = 8; // ULPI clock toggle divider when unlocked
	localparam int RUN_DIV = 2; // ULPI clock toggle divider when locked
	localparam logic [7:0] ULPI_IDLE = 8'h00;
	localparam logic [1:0] REG_LEVEL_RST = 2'h0;
	typedef enum {ST_RESET, ST_LOCK, ST_STPWAIT, ST_RUN, ST_LOWPWR} seq_state_e;
endpackage

// >>> hdl/ulpi_start_if.sv
// Link-side pins between the transceiver sequencer and its link controller.
// Assumes both ends share the testbench clock; data bus is split into in/out/enable.
`timescale 1ns/1ps
interface ulpi_start_if;
	logic reset_pin_n;
	logic reference_clock_input;
	logic stp;
	logic dir;
	logic ulpi_clock_output;
	logic [7:0] data_phy;
	logic data_phy_oe;
	logic [7:0] data_link;
	logic data_link_oe;
	modport phy (input reset_pin_n, reference_clock_input, stp, data_link, data_link_oe,
		output dir, ulpi_clock_output, data_phy, data_phy_oe);
	modport link (output reset_pin_n, reference_clock_input, stp, data_link, data_link_oe,
		input dir, ulpi_clock_output, data_phy, data_phy_oe);
endinterface

// >>> hdl/phy_startup_seq.sv
// Transceiver-end start-up, reset and reference-clock sequencer.
// Assumes pins are asynchronous to CLK and pass two flip-flops before use.
`timescale 1ns/1ps
module phy_startup_seq (
	input wire logic CLK,
	input wire logic RST,
	ulpi_start_if.phy PINS,
	input wire logic POR_OK,
	input wire logic USB_SUPPLY_OK,
	input wire logic LOWPWR_REQ,
	input wire logic UART_MODE,
	input wire logic [1:0] UART_REGULATOR_LEVEL_IN,
	output logic RUNNING,
	output logic FULL_USB,
	output logic PLL_LOCKED,
	output logic [1:0] REGULATOR_LEVEL
);
	import startup_pkg::*;

	// Two-flop synchronisers for reset pin, reference clock and STP
	logic [1:0] rst_s_q, ref_s_q, stp_s_q;
	always_ff @(posedge CLK) begin
		rst_s_q <= {rst_s_q[0], PINS.reset_pin_n}; // see R23
		ref_s_q <= {ref_s_q[0], PINS.reference_clock_input};
		stp_s_q <= {stp_s_q[0], PINS.stp};
	end
	wire rst_pin = rst_s_q[1];
	wire stp = stp_s_q[1];

	// Sequencer, reference watch, divider, regulator and status state
	seq_state_e st_q, st_d;
	logic ref_rise;
	logic ref_last_q, ref_last_d;
	logic [6:0] loss_q, loss_d;
	logic [3:0] div_q, div_d;
	logic clk_out_q, clk_out_d;
	logic [6:0] lock_q, lock_d;
	logic dir_q, dir_d;
	logic [1:0] lvl_q, lvl_d;
	logic ready_q, ready_d;
	logic full_q, full_d;
	logic locked_q, locked_d;

	// Only rising reference edges count; the falling edge carries no timing
	assign ref_rise = ref_s_q[1] & ~ref_last_q; // see R2

	// Edge history and loss timer; the timer saturates so it never wraps
	always_comb begin
		ref_last_d = ref_s_q[1];
		if (ref_rise)
			loss_d = 7'h00;
		else if (loss_q == 7'(REF_LOSS_CYC))
			loss_d = loss_q;
		else
			loss_d = loss_q + 7'h01;
	end

	// Reference watch registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			ref_last_q <= 1'b0;
			loss_q <= 7'h00;
		end else begin
			ref_last_q <= ref_last_d;
			loss_q <= loss_d;
		end
	end

	// ULPI clock divider; an unlocked PLL still toggles, only at its minimum rate
	always_comb begin
		logic [3:0] top;
		top = 4'((st_q == ST_RUN || st_q == ST_STPWAIT) ? RUN_DIV - 1 : MIN_DIV - 1);
		div_d = div_q + 4'h1;
		clk_out_d = clk_out_q;
		// Compare with >= so a lower limit after lock never strands the count
		if (div_q >= top) begin
			div_d = 4'h0;
			clk_out_d = ~clk_out_q; // see R3, R9
		end
	end

	// Divider registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			div_q <= 4'h0;
			clk_out_q <= 1'b0;
		end else begin
			div_q <= div_d;
			clk_out_q <= clk_out_d;
		end
	end

	// Regulator level follows the input only in UART mode once running
	always_comb begin
		lvl_d = lvl_q;
		// Reset wins over a UART update in the same cycle
		if (!rst_pin || !POR_OK)
			lvl_d = REG_LEVEL_RST; // see R12, R13
		else if (UART_MODE && ready_q)
			lvl_d = UART_REGULATOR_LEVEL_IN; // see R10
	end

	// Regulator level register; a power-up returns it to its default
	always_ff @(posedge CLK) begin
		if (RST)
			lvl_q <= REG_LEVEL_RST; // see R13
		else
			lvl_q <= lvl_d;
	end

	// Sequencer next state; DIR is a register, so it moves one cycle after a decision
	always_comb begin
		st_d = st_q;
		lock_d = lock_q;
		dir_d = dir_q;
		ready_d = ready_q;
		unique case (st_q)
			// Waiting for the pin and POR; DIR stays low
			ST_RESET: begin
				dir_d = 1'b0;
				lock_d = 7'h00;
				if (POR_OK && rst_pin) begin // see R5, R11
					st_d = ST_LOCK;
					dir_d = 1'b1; // see R18
				end
			end
			// Lock counts reference edges, so a late reference delays start equally
			ST_LOCK: begin
				if (ref_rise)
					lock_d = lock_q + 7'h01; // see R4
				if (lock_q == 7'(LOCK_EDGES))
					st_d = ST_STPWAIT; // see R1
			end
			// Locked; DIR waits for the link to let go of STP
			ST_STPWAIT: begin
				if (!stp) begin // see R19
					st_d = ST_RUN;
					dir_d = 1'b0;
					ready_d = 1'b1; // see R17
				end
			end
			// Normal operation until low power is requested
			ST_RUN: begin
				if (LOWPWR_REQ)
					st_d = ST_LOWPWR;
			end
			// Only STP brings the device back, and the PLL must relock first
			ST_LOWPWR: begin
				if (stp) begin // see R7
					st_d = ST_LOCK;
					lock_d = 7'h00;
					dir_d = 1'b1;
				end
			end
		endcase
		// Lost reference drops lock in ST_STPWAIT or ST_RUN; DIR is left as it was
		if ((st_q == ST_RUN || st_q == ST_STPWAIT) && loss_q == 7'(REF_LOSS_CYC)) begin
			st_d = ST_LOCK; // see R9
			lock_d = 7'h00;
		end
		// Pin or POR low forces ST_RESET and drops DIR and RUNNING regardless of state
		if (!rst_pin || !POR_OK) begin // see R12, R13
			st_d = ST_RESET;
			dir_d = 1'b0;
			ready_d = 1'b0;
		end
	end

	// State registers; RST models core supply power-up
	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q <= ST_RESET; // see R13
			lock_q <= 7'h00;
			dir_q <= 1'b0;
			ready_q <= 1'b0;
		end else begin
			st_q <= st_d;
			lock_q <= lock_d;
			dir_q <= dir_d;
			ready_q <= ready_d;
		end
	end

	// Full USB only with USB supply; otherwise register access only
	always_comb begin
		// Taken from next values so the flags line up with the state
		full_d = ready_d && USB_SUPPLY_OK; // see R16
		locked_d = (st_d == ST_STPWAIT) || (st_d == ST_RUN);
	end

	// Status flags registered so every output leaves from a flip-flop
	always_ff @(posedge CLK) begin
		if (RST) begin
			full_q <= 1'b0;
			locked_q <= 1'b0;
		end else begin
			full_q <= full_d;
			locked_q <= locked_d;
		end
	end

	// Data bus driven idle whenever DIR is high
	// Link-facing pins and status outputs all come from registers
	assign PINS.dir = dir_q; // see R18
	assign PINS.data_phy = ULPI_IDLE;
	assign PINS.data_phy_oe = dir_q;
	assign PINS.ulpi_clock_output = clk_out_q;
	assign RUNNING = ready_q;
	assign FULL_USB = full_q;
	assign PLL_LOCKED = locked_q;
	assign REGULATOR_LEVEL = lvl_q;
endmodule

// >>> hdl/link_startup_ctl.sv
// Link-end start-up controller: drives reset pin, reference clock and STP.
// Assumes the transceiver pins arrive asynchronously; reference is divided from CLK.
`timescale 1ns/1ps
module link_startup_ctl #(
	parameter int REF_HALF = 8
) (
	input wire logic CLK,
	input wire logic RST,
	ulpi_start_if.link PINS,
	input wire logic SUPPLY_STABLE,
	input wire logic LINK_READY,
	input wire logic SLEEP_REQ,
	input wire logic WAKE_REQ,
	input wire logic IS_HOST,
	output logic PHY_UP,
	output logic AUTO_RESUME_ENABLE
);
	import startup_pkg::*;

	logic [1:0] dir_s_q;
	always_ff @(posedge CLK)
		dir_s_q <= {dir_s_q[0], PINS.dir};
	wire dir = dir_s_q[1];

	logic [10:0] rcnt_q, rcnt_d;
	logic [7:0] div_q, div_d;
	logic ref_q, ref_d, ref_en_q, ref_en_d;
	logic rstn_q, rstn_d, stp_q, stp_d, idle_q, idle_d;
	logic up_q, up_d, ar_q, ar_d, dir_last_q;

	// Controller next values
	always_comb begin
		rcnt_d = rcnt_q;
		div_d = div_q + 8'h01;
		ref_d = ref_q;
		ref_en_d = ref_en_q;
		rstn_d = rstn_q;
		stp_d = stp_q;
		idle_d = 1'b0;
		up_d = up_q;
		ar_d = ar_q;
		if (div_q == 8'(REF_HALF - 1)) begin
			div_d = 8'h00;
			ref_d = ref_en_q ? ~ref_q : 1'b0;
		end
		// Reset held low until supply stable, link ready, and 1 us elapsed
		if (!SUPPLY_STABLE || !LINK_READY) begin // see R14, R15
			rstn_d = 1'b0;
			rcnt_d = 11'h000;
			up_d = 1'b0;
		end else if (!rstn_q) begin
			if (rcnt_q >= 11'(RESET_MIN_CYC))
				rstn_d = 1'b1; // see R12, R21
			else
				rcnt_d = rcnt_q + 11'h001;
		end
		// Idle one cycle after DIR falls
		if (dir_last_q && !dir) begin
			idle_d = 1'b1; // see R20
			up_d = 1'b1;
			stp_d = 1'b0;
			ar_d = IS_HOST; // see R22
		end
		if (up_q && SLEEP_REQ) begin
			up_d = 1'b0;
			ref_en_d = 1'b0; // see R6
		end
		if (!ref_en_q && WAKE_REQ) begin
			ref_en_d = 1'b1; // see R8
			stp_d = 1'b1; // see R7
		end else if (stp_q && !WAKE_REQ) begin
			// DIR cannot fall while STP stands, so STP must drop before DIR does
			stp_d = 1'b0; // see R7
		end
		if (!rstn_q)
			ref_en_d = 1'b1;
	end

	// Controller registers
	always_ff @(posedge CLK) begin
		if (RST) begin
			rcnt_q <= 11'h000;
			div_q <= 8'h00;
			ref_q <= 1'b0;
			ref_en_q <= 1'b1;
			rstn_q <= 1'b0;
			stp_q <= 1'b0;
			idle_q <= 1'b0;
			up_q <= 1'b0;
			ar_q <= 1'b0;
			dir_last_q <= 1'b0;
		end else begin
			rcnt_q <= rcnt_d;
			div_q <= div_d;
			ref_q <= ref_d;
			ref_en_q <= ref_en_d;
			rstn_q <= rstn_d;
			stp_q <= stp_d;
			idle_q <= idle_d;
			up_q <= up_d;
			ar_q <= ar_d;
			dir_last_q <= dir;
		end
	end

	assign PINS.reset_pin_n = rstn_q;
	assign PINS.reference_clock_input = ref_q;
	assign PINS.stp = stp_q;
	assign PINS.data_link = ULPI_IDLE;
	assign PINS.data_link_oe = idle_q | up_q;
	assign PHY_UP = up_q;
	assign AUTO_RESUME_ENABLE = ar_q;
endmodule

// >>> test/ulpi_phy_startup_reset_seq_chk.sv
// Checker for the start-up pins between the sequencer and its link.
// Assumes both ends share CLK and RST resets both.
`timescale 1ns/1ps
module ulpi_phy_startup_reset_seq_chk (
	input wire logic CLK,
	input wire logic RST,
	input wire logic reset_pin_n,
	input wire logic reference_clock_input,
	input wire logic stp,
	input wire logic dir,
	input wire logic [7:0] data_phy,
	input wire logic data_phy_oe,
	input wire logic [7:0] data_link,
	input wire logic data_link_oe
);
	import startup_pkg::*;
	// Sync lag may hide two early edges from our count
	localparam int LOCK_MIN = LOCK_EDGES - 2;
	logic ref_q;
	int ref_cnt_q, ref_cnt_d, low_q, low_d;
	// Reference edges seen while DIR is up, and low time of the reset pin
	always_comb begin
		ref_cnt_d = (RST || !dir) ? 0 : ref_cnt_q + int'(reference_clock_input && !ref_q);
		low_d = (RST || reset_pin_n) ? 0 : (low_q < 1000 ? low_q + 1 : low_q);
	end
	always_ff @(posedge CLK) begin
		ref_q <= reference_clock_input;
		ref_cnt_q <= ref_cnt_d;
		low_q <= low_d;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	chk_phy_idle_data: assert property (data_phy_oe |-> data_phy == ULPI_IDLE)
		else $error("phy data not idle");
	chk_held_in_reset: assert property (!reset_pin_n [*6] |-> !dir)
		else $error("dir up while pin low");
	chk_dir_after_sync: assert property ($rose(reset_pin_n) |-> !dir [*2] ##[1:4] dir)
		else $error("dir did not rise after release");
	chk_lock_edge_count: assert property ($fell(dir) && reset_pin_n |-> ref_cnt_q >= LOCK_MIN)
		else $error("dir fell before lock");
	chk_stp_holds_dir: assert property (dir && stp && reset_pin_n |=> dir)
		else $error("dir fell with stp high");
	chk_stp_low_fall: assert property ($fell(dir) && reset_pin_n |-> !$past(stp, 3))
		else $error("dir fell without stp low");
	chk_link_idle_data: assert property (data_link_oe |-> data_link == ULPI_IDLE)
		else $error("link data not idle");
	chk_reset_pin_width: assert property ($rose(reset_pin_n) |-> low_q >= RESET_MIN_CYC)
		else $error("reset pin pulse too short");
	cover property ($fell(dir) && reset_pin_n);
	cover property (dir && stp);
	cover property ($rose(data_link_oe));
endmodule

// >>> test/ulpi_phy_startup_reset_seq_tb.sv
// Bench joining the sequencer and link ends through their interface.
// Assumes the package constants; the link makes the reference clock.
`timescale 1ns/1ps
module ulpi_phy_startup_reset_seq_tb;
	import startup_pkg::*;
	logic clk = 0, rst = 1, por_ok = 1, usb_ok = 1, lowpwr = 0, uart = 0;
	logic stable = 0, ready = 0, sleep = 0, wake = 0, host = 1;
	logic [1:0] lvl_in = 2'h0;
	logic running, full, locked, up, autores;
	logic [1:0] lvl;
	int err_count = 0;
	int checked = 0;
	int n;
	ulpi_start_if pins ();
	phy_startup_seq phy_startup_seq_inst (.CLK(clk), .RST(rst), .PINS(pins), .POR_OK(por_ok),
		.USB_SUPPLY_OK(usb_ok), .LOWPWR_REQ(lowpwr), .UART_MODE(uart),
		.UART_REGULATOR_LEVEL_IN(lvl_in), .RUNNING(running), .FULL_USB(full),
		.PLL_LOCKED(locked), .REGULATOR_LEVEL(lvl));
	link_startup_ctl #(.REF_HALF(8)) link_startup_ctl_inst (.CLK(clk), .RST(rst), .PINS(pins),
		.SUPPLY_STABLE(stable), .LINK_READY(ready), .SLEEP_REQ(sleep), .WAKE_REQ(wake),
		.IS_HOST(host), .PHY_UP(up), .AUTO_RESUME_ENABLE(autores));
	ulpi_phy_startup_reset_seq_chk ulpi_phy_startup_reset_seq_chk_inst (.CLK(clk), .RST(rst),
		.reset_pin_n(pins.reset_pin_n), .reference_clock_input(pins.reference_clock_input),
		.stp(pins.stp), .dir(pins.dir), .data_phy(pins.data_phy),
		.data_phy_oe(pins.data_phy_oe), .data_link(pins.data_link),
		.data_link_oe(pins.data_link_oe));
	// 200 MHz
	always #2.5 clk = ~clk;
	task automatic final_report();
		if (err_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		checked++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	// Bounded wait: lock takes about a thousand cycles at this reference rate
	task automatic wait_run();
		for (int i = 0; running !== 1'b1; i++) begin
			@(posedge clk);
			if (i > 4000) begin
				chk(0, "wait expired");
				final_report();
			end
		end
	endtask
	// Cycles until the ULPI clock next changes; call twice to align
	task automatic gap(output int k);
		logic c;
		c = pins.ulpi_clock_output;
		k = 0;
		while (pins.ulpi_clock_output === c && k < 50) begin
			@(posedge clk);
			k++;
		end
		if (k >= 50) begin
			chk(0, "ULPI clock stalled");
			final_report();
		end
	endtask
	task automatic t_start();
		stable <= 1;
		repeat (300) @(posedge clk);
		chk(pins.reset_pin_n === 0 && pins.dir === 0, "pin released early");
		ready <= 1;
		wait_run();
		repeat (8) @(posedge clk);
		chk(locked === 1 && full === 1 && pins.dir === 0, "not running");
		chk(up === 1 && pins.data_link_oe === 1 && autores === 1, "link not up");
		gap(n);
		gap(n);
		chk(n === RUN_DIV, "locked clock rate");
	endtask
	// Level follows input only in UART mode
	task automatic t_uart();
		for (int i = 0; i < 4; i++) begin
			uart <= 1;
			lvl_in <= 2'(i);
			repeat (4) @(posedge clk);
			chk(lvl === 2'(i), "level not taken");
		end
		uart <= 0;
		lvl_in <= 2'h1;
		repeat (4) @(posedge clk);
		chk(lvl === 2'h3, "level taken outside UART");
		usb_ok <= 0;
		repeat (4) @(posedge clk);
		chk(full === 0 && running === 1, "full without USB supply");
		usb_ok <= 1;
	endtask
	// Reference stops in sleep; STP wakes and holds DIR until released
	task automatic t_sleep();
		lowpwr <= 1;
		sleep <= 1;
		repeat (600) @(posedge clk);
		chk(locked === 0, "lock kept without reference");
		gap(n);
		gap(n);
		chk(n === MIN_DIV, "unlocked clock rate");
		lowpwr <= 0;
		sleep <= 0;
		wake <= 1;
		repeat (1500) @(posedge clk);
		chk(pins.stp === 1 && pins.dir === 1, "dir low while stp high");
		wake <= 0;
		repeat (20) @(posedge clk);
		chk(pins.dir === 0 && running === 1, "no wake");
	endtask
	task automatic t_reset();
		por_ok <= 0;
		repeat (6) @(posedge clk);
		chk(running === 0 && pins.dir === 0, "run without POR");
		por_ok <= 1;
		wait_run();
		rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		chk(lvl === REG_LEVEL_RST && running === 0 && up === 0, "no defaults");
		wait_run();
	endtask
	// Reference stops while running with no low-power request: lock must drop
	task automatic t_loss();
		sleep <= 1;
		repeat (200) @(posedge clk);
		chk(locked === 0 && running === 1 && pins.dir === 0, "lock kept after loss");
		sleep <= 0;
	endtask
	initial begin
		repeat (4) @(posedge clk);
		rst <= 0;
		t_start();
		t_uart();
		t_sleep();
		t_reset();
		t_loss();
		final_report();
	end
endmodule
